/* File: src/pllps_pkg.sv */
// Package for the first-loop profile select and configuration block.
// Assumes a single 200 MHz system clock and a two-wire serial register port.
package pllps_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_SPREAD_HI = 8'h10;
    localparam logic [7:0] OFS_SPREAD_MID = 8'h11;
    localparam logic [7:0] OFS_SPREAD_LO = 8'h12;
    localparam logic [7:0] OFS_FREQ_SET = 8'h13;
    localparam logic [7:0] OFS_ROUTING = 8'h14;
    localparam logic [7:0] OFS_OUT_STATE = 8'h15;
    localparam logic [7:0] OFS_DIRECTION = 8'h16;

    // ------------------------------------------------------------
    // Field positions in the routing and direction registers, and the spread field width
    // ------------------------------------------------------------
    localparam int POS_BYPASS = 7;
    localparam int POS_SECOND_SRC = 6;
    localparam int POS_THIRD_SRC = 4;
    localparam int POS_STATE_DEF_ONE = 2;
    localparam int POS_STATE_DEF_ZERO = 0;
    localparam int POS_DIRECTION = 7;
    localparam int SPREAD_W = 3;

    // ------------------------------------------------------------
    // Values after reset
    // ------------------------------------------------------------
    localparam logic [23:0] RST_SPREAD = 24'h000000;
    localparam logic [7:0] RST_FREQ_SET = 8'h00;
    localparam logic [7:0] RST_ROUTING = 8'hED;
    localparam logic [7:0] RST_OUT_STATE = 8'h02;
    localparam logic RST_DIRECTION = 1'b0;

    // ------------------------------------------------------------
    // Encodings
    // ------------------------------------------------------------
    localparam logic [2:0] SPREAD_OFF = 3'h0;
    localparam logic [1:0] OST_OFF_PD = 2'h0;
    localparam logic [1:0] OST_HIZ = 2'h1;
    localparam logic [1:0] OST_LOW = 2'h2;
    localparam logic [1:0] OST_ON = 2'h3;
    localparam logic [1:0] SRC_DIV_ONE = 2'h0;
    localparam logic [1:0] SRC_DIV_TWO = 2'h1;
    localparam logic [1:0] SRC_DIV_THREE = 2'h2;

    // Slave address on the serial port; value is arbitrary
    localparam logic [6:0] DEV_ADDR = 7'h65;
    localparam logic [2:0] LAST_BIT = 3'h7;

    typedef enum logic [5:0] {
        SER_IDLE = 6'b000001,
        SER_ADDR = 6'b000010,
        SER_ACK = 6'b000100,
        SER_WBYTE = 6'b001000,
        SER_RBYTE = 6'b010000,
        SER_RACK = 6'b100000
    } pllps_ser_e;

endpackage

/* File: src/pllps_top.sv */
// Profile select and configuration registers for the first synthesizer loop.
// Assumes the host drives the three profile pins and the two-wire serial bus;
// the serial data pin is open drain and resolved outside this module.
`timescale 1ns/1ps
module pllps_top (
    // Clock, reset, enable
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic clk_en,
    // Profile select pins
    input wire logic profile_pin_0,
    input wire logic profile_pin_1,
    input wire logic profile_pin_2,
    // Serial register port
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    // Applied configuration
    output logic [2:0] spread_amount,
    output logic spread_direction,
    output logic second_ratio_set,
    output logic loop_bypass_select,
    output logic loop_power_down,
    output logic second_output_source,
    output logic [1:0] third_output_source,
    output logic [1:0] out_state
);
    import pllps_pkg::*;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [4:0] meta_r;
    logic [4:0] sync_r;
    logic scl_d_r;
    logic sda_d_r;
    logic [4:0] meta_nxt;
    logic [4:0] sync_nxt;

    always_comb begin
        meta_nxt = {scl_i, sda_i, profile_pin_2, profile_pin_1, profile_pin_0};
        sync_nxt = meta_r;
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            meta_r <= 5'h18;
            sync_r <= 5'h18;
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
        end else if (clk_en) begin
            meta_r <= meta_nxt;
            sync_r <= sync_nxt;
            scl_d_r <= sync_r[4];
            sda_d_r <= sync_r[3];
        end
    end

    wire logic scl_s = sync_r[4];
    wire logic sda_s = sync_r[3];
    wire logic [2:0] pin_idx = sync_r[2:0];
    wire logic scl_rise = scl_s && !scl_d_r;
    wire logic scl_fall = !scl_s && scl_d_r;
    wire logic bus_start = scl_s && scl_d_r && sda_d_r && !sda_s;
    wire logic bus_stop = scl_s && scl_d_r && !sda_d_r && sda_s;

    // ------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------
    logic [23:0] spread_r;
    logic [7:0] freq_set_r;
    logic [7:0] routing_r;
    logic [7:0] out_choice_r;
    logic direction_r;
    logic [23:0] spread_nxt;
    logic [7:0] freq_set_nxt;
    logic [7:0] routing_nxt;
    logic [7:0] out_choice_nxt;
    logic direction_nxt;

    // Unmapped offsets read as zero
    function automatic logic [7:0] reg_read(input logic [7:0] ofs, input logic [23:0] spr,
                                            input logic [7:0] fs, input logic [7:0] rt,
                                            input logic [7:0] oc, input logic dir);
        logic [7:0] val;
        val = 8'h00;
        if (ofs == OFS_SPREAD_HI) begin
            val = spr[23:16];
        end else if (ofs == OFS_SPREAD_MID) begin
            val = spr[15:8];
        end else if (ofs == OFS_SPREAD_LO) begin
            val = spr[7:0];
        end else if (ofs == OFS_FREQ_SET) begin
            val = fs;
        end else if (ofs == OFS_ROUTING) begin
            val = rt;
        end else if (ofs == OFS_OUT_STATE) begin
            val = oc;
        end else if (ofs == OFS_DIRECTION) begin
            val = {dir, 7'h00};
        end
        return val;
    endfunction

    // ------------------------------------------------------------
    // Serial slave state
    // ------------------------------------------------------------
    pllps_ser_e state_r;
    pllps_ser_e state_nxt;
    logic [2:0] bit_r;
    logic [2:0] bit_nxt;
    logic [7:0] shift_r;
    logic [7:0] shift_nxt;
    logic [7:0] ptr_r;
    logic [7:0] ptr_nxt;
    logic read_r;
    logic read_nxt;
    logic have_ofs_r;
    logic have_ofs_nxt;
    logic armed_r;
    logic armed_nxt;
    logic sda_oe_r;
    logic sda_oe_nxt;
    logic do_write;
    logic [7:0] rd_byte;

    always_comb begin
        state_nxt = state_r;
        bit_nxt = bit_r;
        shift_nxt = shift_r;
        ptr_nxt = ptr_r;
        read_nxt = read_r;
        have_ofs_nxt = have_ofs_r;
        armed_nxt = armed_r;
        sda_oe_nxt = sda_oe_r;
        do_write = 1'b0;
        rd_byte = reg_read(ptr_r, spread_r, freq_set_r, routing_r, out_choice_r, direction_r);
        if (bus_start) begin
            state_nxt = SER_ADDR;
            bit_nxt = 3'h0;
            armed_nxt = 1'b0;
            sda_oe_nxt = 1'b0;
        end else if (bus_stop) begin
            state_nxt = SER_IDLE;
            sda_oe_nxt = 1'b0;
        end else begin
            case (state_r)
                SER_ADDR, SER_WBYTE: begin
                    // The clock fall that closes a start carries no bit, so only falls after a sampled rise count
                    if (scl_rise) begin
                        shift_nxt = {shift_r[6:0], sda_s};
                        armed_nxt = 1'b1;
                    end else if (scl_fall && armed_r) begin
                        armed_nxt = 1'b0;
                        bit_nxt = bit_r + 3'h1;
                        if (bit_r == LAST_BIT) begin
                            sda_oe_nxt = 1'b1;
                            state_nxt = SER_ACK;
                            if (state_r == SER_ADDR) begin
                                read_nxt = shift_r[0];
                                have_ofs_nxt = 1'b0;
                                if (shift_r[7:1] != DEV_ADDR) begin
                                    sda_oe_nxt = 1'b0;
                                    state_nxt = SER_IDLE;
                                end
                            end else if (!have_ofs_r) begin
                                ptr_nxt = shift_r;
                                have_ofs_nxt = 1'b1;
                            end else begin
                                do_write = 1'b1;
                                ptr_nxt = ptr_r + 8'h01;
                            end
                        end
                    end
                end
                SER_ACK, SER_RACK: begin
                    if (scl_rise && state_r == SER_RACK && sda_s) begin
                        state_nxt = SER_IDLE;
                    end else if (scl_fall) begin
                        bit_nxt = 3'h0;
                        if (read_r) begin
                            shift_nxt = rd_byte;
                            ptr_nxt = ptr_r + 8'h01;
                            sda_oe_nxt = !rd_byte[7];
                            state_nxt = SER_RBYTE;
                        end else begin
                            sda_oe_nxt = 1'b0;
                            state_nxt = SER_WBYTE;
                        end
                    end
                end
                SER_RBYTE: begin
                    if (scl_fall) begin
                        bit_nxt = bit_r + 3'h1;
                        shift_nxt = {shift_r[6:0], 1'b0};
                        if (bit_r == LAST_BIT) begin
                            sda_oe_nxt = 1'b0;
                            state_nxt = SER_RACK;
                        end else begin
                            sda_oe_nxt = !shift_r[6];
                        end
                    end
                end
                default: begin
                    sda_oe_nxt = 1'b0;
                    state_nxt = SER_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            state_r <= SER_IDLE;
            bit_r <= 3'h0;
            shift_r <= 8'h00;
            ptr_r <= 8'h00;
            read_r <= 1'b0;
            have_ofs_r <= 1'b0;
            armed_r <= 1'b0;
            sda_oe_r <= 1'b0;
        end else if (clk_en) begin
            state_r <= state_nxt;
            bit_r <= bit_nxt;
            shift_r <= shift_nxt;
            ptr_r <= ptr_nxt;
            read_r <= read_nxt;
            have_ofs_r <= have_ofs_nxt;
            armed_r <= armed_nxt;
            sda_oe_r <= sda_oe_nxt;
        end
    end

    // ------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------
    // Writes to unmapped offsets, including those above 40h, are dropped
    always_comb begin
        spread_nxt = spread_r;
        freq_set_nxt = freq_set_r;
        routing_nxt = routing_r;
        out_choice_nxt = out_choice_r;
        direction_nxt = direction_r;
        if (do_write) begin
            if (ptr_r == OFS_SPREAD_HI) begin
                spread_nxt[23:16] = shift_r;
            end else if (ptr_r == OFS_SPREAD_MID) begin
                spread_nxt[15:8] = shift_r;
            end else if (ptr_r == OFS_SPREAD_LO) begin
                spread_nxt[7:0] = shift_r;
            end else if (ptr_r == OFS_FREQ_SET) begin
                freq_set_nxt = shift_r;
            end else if (ptr_r == OFS_ROUTING) begin
                routing_nxt = shift_r;
            end else if (ptr_r == OFS_OUT_STATE) begin
                out_choice_nxt = shift_r;
            end else if (ptr_r == OFS_DIRECTION) begin
                direction_nxt = shift_r[POS_DIRECTION];
            end
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            spread_r <= RST_SPREAD;
            freq_set_r <= RST_FREQ_SET;
            routing_r <= RST_ROUTING;
            out_choice_r <= RST_OUT_STATE;
            direction_r <= RST_DIRECTION;
        end else if (clk_en) begin
            spread_r <= spread_nxt;
            freq_set_r <= freq_set_nxt;
            routing_r <= routing_nxt;
            out_choice_r <= out_choice_nxt;
            direction_r <= direction_nxt;
        end
    end

    // ------------------------------------------------------------
    // Applied profile
    // ------------------------------------------------------------
    // Recomputed every cycle with clk_en high from the pins, so a pin change needs no write
    logic [2:0] amount_nxt;
    logic [1:0] ostate_nxt;
    logic [1:0] third_nxt;

    always_comb begin
        amount_nxt = spread_r[pin_idx * SPREAD_W +: SPREAD_W];
        ostate_nxt = out_choice_r[pin_idx] ? routing_r[POS_STATE_DEF_ONE +: 2]
                                           : routing_r[POS_STATE_DEF_ZERO +: 2];
        third_nxt = routing_r[POS_THIRD_SRC +: 2];
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            spread_amount <= SPREAD_OFF;
            spread_direction <= RST_DIRECTION;
            second_ratio_set <= 1'b0;
            loop_bypass_select <= 1'b1;
            loop_power_down <= 1'b1;
            second_output_source <= 1'b1;
            third_output_source <= SRC_DIV_THREE;
            out_state <= OST_HIZ;
            sda_o <= 1'b0;
            sda_oe <= 1'b0;
        end else if (clk_en) begin
            spread_amount <= amount_nxt;
            spread_direction <= direction_r;
            second_ratio_set <= freq_set_r[pin_idx];
            loop_bypass_select <= routing_r[POS_BYPASS];
            loop_power_down <= routing_r[POS_BYPASS] || (ostate_nxt == OST_OFF_PD);
            second_output_source <= routing_r[POS_SECOND_SRC];
            third_output_source <= third_nxt;
            out_state <= ostate_nxt;
            sda_o <= 1'b0;
            sda_oe <= sda_oe_nxt;
        end
    end

endmodule

/* File: testbench/pllps_top_assertions.sv */
// Checker for the profile select block, bound to its top-level ports.
// Assumes one clock domain and an open-drain data wire resolved outside.
`timescale 1ns/1ps
module pllps_top_checker (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic clk_en,
    // Pins
    input wire logic profile_pin_0,
    input wire logic profile_pin_1,
    input wire logic profile_pin_2,
    input wire logic scl_i,
    input wire logic sda_o,
    input wire logic sda_oe,
    // Applied configuration
    input wire logic [2:0] spread_amount,
    input wire logic spread_direction,
    input wire logic second_ratio_set,
    input wire logic loop_bypass_select,
    input wire logic loop_power_down,
    input wire logic second_output_source,
    input wire logic [1:0] third_output_source,
    input wire logic [1:0] out_state
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    logic [2:0] pins;
    logic [11:0] applied;
    assign pins = {profile_pin_2, profile_pin_1, profile_pin_0};
    assign applied = {spread_amount, spread_direction, second_ratio_set, loop_bypass_select,
                      loop_power_down, second_output_source, third_output_source, out_state};

    bypass_powers_down_a: assert property (loop_bypass_select |-> loop_power_down)
        else $error("bypass without loop power down");
    off_state_down_a: assert property (out_state == 2'h0 |-> loop_power_down)
        else $error("state 00 without loop power down");
    down_has_cause_a: assert property (loop_power_down |-> loop_bypass_select || out_state == 2'h0)
        else $error("loop powered down without cause");
    open_drain_a: assert property (sda_o == 1'b0)
        else $error("data pin driven high");
    reset_defaults_a: assert property ($rose(arst_n) |-> loop_bypass_select && second_output_source
        && third_output_source == 2'h2 && spread_amount == 3'h0 && !second_ratio_set)
        else $error("wrong value out of reset");
    idle_hold_a: assert property ((clk_en && scl_i && $stable(pins))[*6] |=> $stable(applied))
        else $error("applied setting moved with pins and bus idle");
    sda_low_phase_a: assert property ($changed(sda_oe) |-> !scl_i)
        else $error("data wire changed while clock high");
    ack_stands_a: assert property ($rose(sda_oe) |=> sda_oe [*8])
        else $error("data wire pull too short");

    cover property (!loop_bypass_select && !loop_power_down);
    cover property (spread_amount == 3'h7);
    cover property ($rose(sda_oe));
endmodule

bind pllps_top pllps_top_checker u_chk (.clk_sys, .arst_n, .clk_en, .profile_pin_0, .profile_pin_1,
    .profile_pin_2, .scl_i, .sda_o, .sda_oe, .spread_amount, .spread_direction, .second_ratio_set,
    .loop_bypass_select, .loop_power_down, .second_output_source, .third_output_source, .out_state);

/* File: testbench/pllps_host_model.sv */
// Behavioural host on the two-wire serial port of the profile select block.
// Assumes the bench resolves the data wire with a pull-up.
`timescale 1ns/1ps
module pllps_host_model
    import pllps_pkg::*;
(
    // Clock
    input wire logic clk_sys,
    // Serial wire
    input wire logic sda_line,
    output logic scl,
    output logic sda_drv
);
    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end
    // Ten clocks per phase keeps every phase above the eight the port needs
    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    task automatic put_bit(input logic b);
        wait_clk(3);
        sda_drv <= b;
        wait_clk(7);
        scl <= 1'b1;
        wait_clk(10);
        scl <= 1'b0;
    endtask
    task automatic get_bit(output logic b);
        wait_clk(3);
        sda_drv <= 1'b1;
        wait_clk(7);
        scl <= 1'b1;
        wait_clk(10);
        b = sda_line;
        scl <= 1'b0;
    endtask
    // Also serves as repeated start with the clock low
    task automatic start();
        wait_clk(3);
        sda_drv <= 1'b1;
        wait_clk(7);
        scl <= 1'b1;
        wait_clk(10);
        sda_drv <= 1'b0;
        wait_clk(10);
        scl <= 1'b0;
    endtask
    task automatic stop();
        wait_clk(3);
        sda_drv <= 1'b0;
        wait_clk(7);
        scl <= 1'b1;
        wait_clk(10);
        sda_drv <= 1'b1;
        wait_clk(10);
    endtask
    task automatic sbyte(input logic [7:0] d, inout logic ok);
        logic a;
        for (int i = 7; i >= 0; i--) put_bit(d[i]);
        get_bit(a);
        ok = ok & ~a;
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] off, input logic [7:0] d, output logic ok);
        ok = 1'b1;
        start();
        sbyte({a, 1'b0}, ok);
        sbyte(off, ok);
        sbyte(d, ok);
        stop();
    endtask
    task automatic rd(input logic [7:0] off, output logic [7:0] d, output logic ok);
        ok = 1'b1;
        start();
        sbyte({DEV_ADDR, 1'b0}, ok);
        sbyte(off, ok);
        start();
        sbyte({DEV_ADDR, 1'b1}, ok);
        for (int i = 7; i >= 0; i--) get_bit(d[i]);
        put_bit(1'b1);
        stop();
    endtask
endmodule

/* File: testbench/pllps_top_tb.sv */
// Self-checking bench for the profile select block.
// Assumes the host model in its own file and a pull-up on the data wire.
`timescale 1ns/1ps
module pllps_top_tb;
    import pllps_pkg::*;
    logic clk_sys = 1'b0;
    logic arst_n = 1'b0;
    logic clk_en = 1'b1;
    logic [2:0] pins = 3'h0;
    logic scl, sda_drv, sda_line, sda_o, sda_oe, ok;
    logic [2:0] spread_amount;
    logic [1:0] third_output_source, out_state;
    logic spread_direction, second_ratio_set, loop_bypass_select, loop_power_down, second_output_source;
    logic [7:0] rd_v;
    int n_mismatch = 0;
    int num_checks = 0;
    int regs [16:22];
    int rt [4] = '{'h00, 'hD9, 'h6E, 'h97};

    always #2.5 clk_sys = ~clk_sys;
    assign sda_line = sda_drv & ~sda_oe;

    pllps_host_model host (.clk_sys(clk_sys), .sda_line(sda_line), .scl(scl), .sda_drv(sda_drv));
    pllps_top uut (.clk_sys(clk_sys), .arst_n(arst_n), .clk_en(clk_en), .profile_pin_0(pins[0]),
        .profile_pin_1(pins[1]), .profile_pin_2(pins[2]), .scl_i(scl), .sda_i(sda_line), .sda_o(sda_o),
        .sda_oe(sda_oe), .spread_amount(spread_amount), .spread_direction(spread_direction),
        .second_ratio_set(second_ratio_set), .loop_bypass_select(loop_bypass_select),
        .loop_power_down(loop_power_down), .second_output_source(second_output_source),
        .third_output_source(third_output_source), .out_state(out_state));

    task automatic print_verdict();
        if (n_mismatch == 0 && num_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Profile i sits at bits 3i+2..3i of the three spread bytes
    function automatic logic [11:0] expect_out(int idx);
        int spr, st;
        spr = ((regs[16] << 16 | regs[17] << 8 | regs[18]) >> (3 * idx)) & 7;
        st = regs[21][idx] ? (regs[20] >> 2) & 3 : regs[20] & 3;
        return {spr[2:0], regs[22][7], regs[19][idx], regs[20][7], regs[20][7] | (st == 0),
                regs[20][6], regs[20][5:4], st[1:0]};
    endfunction
    task automatic apply(input int idx);
        @(posedge clk_sys);
        pins <= idx[2:0];
        repeat (5) @(posedge clk_sys);
        #1;
        chk({spread_amount, spread_direction, second_ratio_set, loop_bypass_select, loop_power_down,
             second_output_source, third_output_source, out_state}, expect_out(idx));
    endtask
    task automatic wr(input int off, input int d);
        host.wr(DEV_ADDR, off[7:0], d[7:0], ok);
        chk({11'h0, ok}, 12'h001);
        if (off >= 16 && off <= 22) regs[off] = (off == 22) ? d & 'h80 : d & 'hFF;
    endtask
    task automatic rdchk(input int off);
        int exp;
        host.rd(off[7:0], rd_v, ok);
        exp = (off >= 16 && off <= 22) ? regs[off] : 0;
        chk({3'h0, ok, rd_v}, {4'h1, exp[7:0]});
    endtask

    initial begin
        int seed;
        seed = $urandom(22);
        regs = '{0, 0, 0, 0, 'hED, 'h02, 0};
        repeat (5) @(posedge clk_sys);
        arst_n <= 1'b1;
        for (int i = 0; i < 8; i++) apply(i);
        for (int o = 16; o <= 23; o++) rdchk(o);
        // All eight spread codes, profile i gets code i; offsets stay below 40h
        wr(16, 'hFA);
        wr(17, 'hC6);
        wr(18, 'h88);
        wr(19, $urandom & 'hFF);
        for (int k = 0; k < 4; k++) begin
            wr(20, rt[k]);
            wr(21, $urandom & 'hFF);
            wr(22, k << 6);
            for (int o = 19; o <= 22; o++) rdchk(o);
            for (int i = 0; i < 8; i++) apply(i);
        end
        // A low enable freezes the applied profile, pins included, until it returns
        @(posedge clk_sys);
        clk_en <= 1'b0;
        pins <= 3'h2;
        repeat (6) @(posedge clk_sys);
        chk({spread_amount, spread_direction, second_ratio_set, loop_bypass_select, loop_power_down,
             second_output_source, third_output_source, out_state}, expect_out(7));
        clk_en <= 1'b1;
        apply(2);
        // A foreign address must be ignored without acknowledge
        host.wr(DEV_ADDR ^ 7'h01, 8'h14, 8'hFF, ok);
        chk({11'h0, ok}, 12'h000);
        rdchk(20);
        print_verdict();
    end
    initial begin
        repeat (90000) @(posedge clk_sys);
        n_mismatch++;
        print_verdict();
    end
endmodule
